// File: rtl/mcbd_pkg.sv
/*
 * mcbd_pkg: constants for the modem controller external bus decode block.
 * Assumes a single 50 MHz core clock; all counts are derived from it here.
 */
package mcbd_pkg;

	// ------------------------------------------------------------------
	// clocking
	// ------------------------------------------------------------------
	localparam longint REF_CLK_HZ = 50000000;
	localparam longint HALF_CLK_HZ = 9830400;
	localparam int PHASE_W = 24;
	// phase step of the clock-out synthesiser, rounded to nearest
	localparam logic [23:0] PHASE_STEP =
		24'((HALF_CLK_HZ * (64'd1 << PHASE_W) + REF_CLK_HZ / 2) / REF_CLK_HZ);

	// ------------------------------------------------------------------
	// bus cycle timing
	// ------------------------------------------------------------------
	localparam int STROBE_NS = 60;
	localparam int CLK_PERIOD_NS = 20;
	// least time: round up
	localparam logic [3:0] STROBE_CYC =
		4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] STROBE_CNT_ZERO = 4'h0;
	localparam logic [3:0] STROBE_CNT_ONE = 4'h1;

	// ------------------------------------------------------------------
	// address map
	// ------------------------------------------------------------------
	localparam logic [15:0] RESET_VECTOR = 16'h2000;
	localparam logic [15:0] PUMP_LO_BASE = 16'h1000;
	localparam logic [15:0] PUMP_LO_LAST = 16'h10FF;
	localparam logic [15:0] SECOND_BASE = 16'h1100;
	localparam logic [15:0] SECOND_LAST = 16'h11FF;
	localparam logic [15:0] PUMP_HI_BASE = 16'h1200;
	localparam logic [15:0] PUMP_HI_LAST = 16'h12FF;
	localparam logic [15:0] DATA_MEM_BASE = 16'h4000;
	localparam logic [15:0] DATA_MEM_LAST = 16'h7FFF;
	localparam logic [15:0] PROG_MEM_BASE = 16'h8000;
	localparam logic [15:0] PROG_MEM_LAST = 16'hFFFF;
	localparam int EXT_ADDR_W = 15;
	localparam logic [7:0] UNMAPPED_RDATA = 8'hFF;
	localparam logic [15:0] PC_STEP = 16'h0001;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MCBD_IDLE  = 3'h0,
		MCBD_LATCH = 3'h1,
		MCBD_HOLD  = 3'h3,
		MCBD_STRB  = 3'h2,
		MCBD_DONE  = 3'h6
	} mcbd_state_t;

	typedef enum logic [2:0] {
		MCBD_SEL_NONE   = 3'h0,
		MCBD_SEL_PUMP   = 3'h1,
		MCBD_SEL_SECOND = 3'h2,
		MCBD_SEL_DATA   = 3'h3,
		MCBD_SEL_PROG   = 3'h4
	} mcbd_sel_t;

endpackage

// File: rtl/mcbd_edge.sv
/*
 * mcbd_edge: rising edge detector for the pump interrupt line.
 * Assumes the input is already synchronous to ref_clk.
 */
`timescale 1ns/100ps
module mcbd_edge
	import mcbd_pkg::*;
(
	input wire logic ref_clk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic level_in, // level to watch
	output logic rise_pulse // one cycle on a low-to-high change
);

	logic prev_r;
	logic prev_nxt;
	logic rise_r;
	logic rise_nxt;

	always_comb begin
		prev_nxt = level_in;
		// the level itself never fires; only a fresh rise does
		rise_nxt = level_in & ~prev_r;
	end

	// starts high so a line already high at reset is not taken as an edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b1;
			rise_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign rise_pulse = rise_r;

endmodule

// File: rtl/mcbd_top.sv
/*
 * mcbd_top: external bus side of a modem controller core. Decodes core
 * accesses into chip selects, runs latch/read/write cycles on the muxed
 * pump bus, takes the pump interrupt, drives the standby indicator and
 * the synthesised clock output, and holds the reset vector.
 * Assumes all inputs are synchronous to ref_clk and that the core waits
 * on req_ready / rsp_valid.
 */
`timescale 1ns/100ps

module mcbd_top
	import mcbd_pkg::*;
(
	input wire logic ref_clk, // 50 MHz core clock
	input wire logic rst, // async master reset, active high
	// core access port
	input wire logic req_valid, // access request
	input wire logic req_write, // 1 write, 0 read
	input wire logic req_fetch, // access is an instruction fetch
	input wire logic [15:0] req_addr, // access address
	input wire logic [7:0] req_wdata, // write data
	output logic req_ready, // request accepted this cycle
	output logic rsp_valid, // one-cycle end of access
	output logic [7:0] rsp_rdata, // read data
	// core control
	input wire logic pc_advance, // step the program counter
	input wire logic expand_bank, // firmware bank setting
	input wire logic power_down, // firmware power-down state
	output logic [15:0] pc_out, // program counter
	output logic pump_irq_pulse, // one cycle per pump interrupt
	// external pins
	output logic [14:0] ext_addr_bus, // external memory address
	output logic data_mem_select, // external data memory select
	output logic prog_mem_select, // external program memory select
	output logic secondary_select_n, // secondary select, low active
	output logic pump_select_n, // pump select, low active
	output logic addr_latch, // address latch strobe
	output logic read_strobe_n, // read strobe, low active
	output logic write_strobe_n, // write strobe, low active
	input wire logic [7:0] muxed_bus_i, // muxed bus in
	output logic [7:0] muxed_bus_o, // muxed bus out
	output logic muxed_bus_oe, // muxed bus drive enable
	input wire logic pump_irq_in, // pump interrupt line
	output logic standby_flag_n_o, // standby pin drive value
	output logic standby_flag_n_oe, // standby pin drive enable
	output logic half_clock_out // synthesised clock output
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// priority order makes the windows exclusive
	function automatic mcbd_sel_t decode(input logic [15:0] a, input logic fetch,
		input logic bank);
		if (in_range(a, PUMP_LO_BASE, PUMP_LO_LAST) ||
			in_range(a, PUMP_HI_BASE, PUMP_HI_LAST)) begin
			decode = MCBD_SEL_PUMP;
		end else if (in_range(a, SECOND_BASE, SECOND_LAST)) begin
			decode = MCBD_SEL_SECOND;
		end else if (in_range(a, DATA_MEM_BASE, DATA_MEM_LAST)) begin
			decode = MCBD_SEL_DATA;
		end else if (in_range(a, PROG_MEM_BASE, PROG_MEM_LAST)) begin
			// expanded bank fetches go through the secondary select
			decode = (fetch && bank) ? MCBD_SEL_SECOND : MCBD_SEL_PROG;
		end else begin
			decode = MCBD_SEL_NONE;
		end
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	// one access at a time: the core waits on req_ready, so no request
	// queue is kept and a new address can never disturb a running cycle
	mcbd_state_t state_r;
	mcbd_state_t state_nxt;
	mcbd_sel_t sel_r;
	mcbd_sel_t sel_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic wr_r;
	logic wr_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [7:0] wdata_r;
	logic [7:0] wdata_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rsp_r;
	logic rsp_nxt;
	logic ale_r;
	logic ale_nxt;
	logic rd_n_r;
	logic rd_n_nxt;
	logic wr_n_r;
	logic wr_n_nxt;
	logic [7:0] bus_o_r;
	logic [7:0] bus_o_nxt;
	logic bus_oe_r;
	logic bus_oe_nxt;
	logic bank_r;
	logic bank_nxt;

	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		rsp_nxt = 1'b0;
		ale_nxt = 1'b0;
		rd_n_nxt = 1'b1;
		wr_n_nxt = 1'b1;
		bus_o_nxt = bus_o_r;
		bus_oe_nxt = 1'b0;
		// bank only changes between accesses so a cycle never switches
		// memory halfway through
		bank_nxt = (state_r == MCBD_IDLE) ? expand_bank : bank_r;
		case (state_r)
			MCBD_IDLE: begin
				sel_nxt = MCBD_SEL_NONE;
				if (req_valid) begin
					state_nxt = MCBD_LATCH;
					sel_nxt = decode(req_addr, req_fetch, bank_r);
					wr_nxt = req_write;
					addr_nxt = req_addr;
					wdata_nxt = req_wdata;
					// address and selects go out with the latch pulse high
					ale_nxt = 1'b1;
					bus_o_nxt = req_addr[7:0];
					bus_oe_nxt = 1'b1;
				end
			end
			MCBD_LATCH: begin
				// latch falls here while address and selects still stand
				state_nxt = MCBD_HOLD;
				bus_oe_nxt = 1'b1;
			end
			MCBD_HOLD: begin
				// strobe opens a cycle after the latch falls, giving address hold
				state_nxt = MCBD_STRB;
				cnt_nxt = STROBE_CYC;
				if (wr_r) begin
					wr_n_nxt = 1'b0;
					bus_o_nxt = wdata_r;
					bus_oe_nxt = 1'b1;
				end else begin
					rd_n_nxt = 1'b0;
				end
			end
			MCBD_STRB: begin
				cnt_nxt = cnt_r - STROBE_CNT_ONE;
				bus_oe_nxt = wr_r;
				if (cnt_r == STROBE_CNT_ONE) begin
					// strobe rises next edge; read data taken on that edge
					state_nxt = MCBD_DONE;
					if (!wr_r) begin
						// unmapped reads give a fixed pattern, not a floating bus
						rdata_nxt = (sel_r == MCBD_SEL_NONE) ? UNMAPPED_RDATA :
							muxed_bus_i;
					end
				end else begin
					wr_n_nxt = ~wr_r;
					rd_n_nxt = wr_r;
				end
			end
			MCBD_DONE: begin
				// write data held one cycle past the strobe rise
				state_nxt = MCBD_IDLE;
				rsp_nxt = 1'b1;
				cnt_nxt = STROBE_CNT_ZERO;
			end
			default: begin
				state_nxt = MCBD_IDLE;
				sel_nxt = MCBD_SEL_NONE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= MCBD_IDLE;
			sel_r <= MCBD_SEL_NONE;
			cnt_r <= STROBE_CNT_ZERO;
			wr_r <= 1'b0;
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
			rsp_r <= 1'b0;
			ale_r <= 1'b0;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			bus_o_r <= 8'h00;
			bus_oe_r <= 1'b0;
			bank_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			rsp_r <= rsp_nxt;
			ale_r <= ale_nxt;
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			bus_o_r <= bus_o_nxt;
			bus_oe_r <= bus_oe_nxt;
			bank_r <= bank_nxt;
		end
	end

	// ------------------------------------------------------------------
	// program counter, clock synthesiser, standby
	// ------------------------------------------------------------------
	// the counter only steps when the core asks; fetch sequencing and
	// branching stay in the core, this block only holds the reset vector
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [23:0] phase_r;
	logic [23:0] phase_nxt;
	logic pd_r;
	logic pd_nxt;

	always_comb begin
		pc_nxt = pc_advance ? pc_r + PC_STEP : pc_r;
		// accumulator keeps the long-run rate within the rounding of PHASE_STEP at the cost of
		// one reference period of edge jitter
		phase_nxt = phase_r + PHASE_STEP;
		pd_nxt = power_down;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_r <= RESET_VECTOR;
			phase_r <= 24'h000000;
			pd_r <= 1'b0;
		end else begin
			pc_r <= pc_nxt;
			phase_r <= phase_nxt;
			pd_r <= pd_nxt;
		end
	end

	// the line is taken as synchronous; a raw pin needs a synchroniser first
	mcbd_edge i_mcbd_edge (
		.ref_clk(ref_clk),
		.rst(rst),
		.level_in(pump_irq_in),
		.rise_pulse(pump_irq_pulse)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// combinational so a request is taken in the very cycle idle is reached
	assign req_ready = (state_r == MCBD_IDLE);
	assign rsp_valid = rsp_r;
	assign rsp_rdata = rdata_r;
	assign pc_out = pc_r;
	assign ext_addr_bus = addr_r[EXT_ADDR_W-1:0];
	// every select comes from one registered code, so the selects can
	// neither glitch nor overlap
	assign pump_select_n = ~(sel_r == MCBD_SEL_PUMP);
	assign secondary_select_n = ~(sel_r == MCBD_SEL_SECOND);
	assign data_mem_select = (sel_r == MCBD_SEL_DATA);
	assign prog_mem_select = (sel_r == MCBD_SEL_PROG);
	assign addr_latch = ale_r;
	assign read_strobe_n = rd_n_r;
	assign write_strobe_n = wr_n_r;
	assign muxed_bus_o = bus_o_r;
	assign muxed_bus_oe = bus_oe_r;
	// open drain: only ever pulls low
	assign standby_flag_n_o = 1'b0;
	assign standby_flag_n_oe = pd_r;
	assign half_clock_out = phase_r[PHASE_W-1];

endmodule

// File: tb/mcbd_top_asserts.sv
/* mcbd_checker: timing and decode properties seen at the mcbd_top ports.
   assumes it is bound into mcbd_top; one clock, reset async active high. */
`timescale 1ns/100ps
module mcbd_checker (
	input wire logic ref_clk, // core clock
	input wire logic rst, // reset
	input wire logic req_valid, // request
	input wire logic req_ready, // ready
	input wire logic [15:0] req_addr, // address
	input wire logic [14:0] ext_addr_bus, // external address
	input wire logic data_mem_select, // data select
	input wire logic prog_mem_select, // program select
	input wire logic secondary_select_n, // secondary select
	input wire logic pump_select_n, // pump select
	input wire logic addr_latch, // latch strobe
	input wire logic read_strobe_n, // read strobe
	input wire logic write_strobe_n, // write strobe
	input wire logic [7:0] muxed_bus_o, // bus drive value
	input wire logic muxed_bus_oe, // bus drive enable
	input wire logic pump_irq_in, // interrupt line
	input wire logic pump_irq_pulse, // interrupt pulse
	input wire logic power_down, // standby request
	input wire logic standby_flag_n_oe // standby drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic taken = req_valid && req_ready;

	AST_LATCH_FALL: assert property (addr_latch |=> !addr_latch && muxed_bus_oe
		&& $stable(pump_select_n) && $stable(secondary_select_n) && $stable(muxed_bus_o))
		else $error("latch pulse too long or address moved at its fall");
	AST_ONE_SELECT: assert property ($onehot0({data_mem_select, prog_mem_select,
		!secondary_select_n, !pump_select_n})) else $error("more than one select active");
	AST_READ_PULSE: assert property ($fell(read_strobe_n) |->
		(!read_strobe_n && !muxed_bus_oe) [*3] ##1 read_strobe_n)
		else $error("read strobe width or bus release wrong");
	AST_WRITE_HOLD: assert property ($rose(write_strobe_n) |->
		muxed_bus_oe && $stable(muxed_bus_o)) else $error("write data not held at strobe rise");
	AST_EXT_ADDR: assert property (taken |=> addr_latch &&
		{1'b0, ext_addr_bus} == ($past(req_addr) & 16'h7FFF))
		else $error("external address wrong");
	AST_DATA_DEC: assert property (taken && req_addr[15:14] == 2'h1 |=> data_mem_select)
		else $error("data memory select missing");
	AST_PUMP_DEC: assert property (taken && (req_addr[15:8] == 8'h10 ||
		req_addr[15:8] == 8'h12) |=> !pump_select_n) else $error("pump select missing");
	AST_SECOND_DEC: assert property (taken && req_addr[15:8] == 8'h11
		|=> !secondary_select_n) else $error("secondary select missing");
	AST_IRQ_EDGE: assert property ($rose(pump_irq_in) |->
		##[1:2] pump_irq_pulse ##1 !pump_irq_pulse) else $error("interrupt edge not taken once");
	AST_STANDBY: assert property (power_down |=> standby_flag_n_oe)
		else $error("standby indicator not driven");
endmodule

// File: tb/mcbd_pump_model.sv
/* mcbd_pump_model: pump chip and memories on the muxed bus.
   assumes the bench merges all selects into one any-select input. */
`timescale 1ns/100ps
module mcbd_pump_model #(
	parameter logic [7:0] KEY = 8'h3C
) (
	input wire logic ref_clk, // core clock
	input wire logic addr_latch, // latch strobe
	input wire logic any_sel, // some select active
	input wire logic read_strobe_n, // read strobe
	input wire logic [7:0] bus_o, // device drive
	output logic [7:0] bus_i // model drive
);
	logic [7:0] lat_r;
	initial bus_i = 8'h00;
	always @(posedge ref_clk) begin
		if (addr_latch) begin
			lat_r <= bus_o;
		end
		// off the bus the value toggles, so stale data never looks valid
		if (!read_strobe_n && any_sel) begin
			bus_i <= lat_r ^ KEY;
		end else begin
			bus_i <= ~bus_i;
		end
	end
endmodule

// File: tb/tb_mcbd_top.sv
/* tb_mcbd_top: directed scenarios for the bus decode block.
   assumes the pump model answers reads with the latched address xor KEY. */
`timescale 1ns/100ps
module tb_mcbd_top;
	logic ref_clk, rst, req_valid, req_write, req_fetch, req_ready, rsp_valid, pc_advance;
	logic expand_bank, power_down, pump_irq_pulse, data_mem_select, prog_mem_select;
	logic secondary_select_n, pump_select_n, addr_latch, read_strobe_n, write_strobe_n;
	logic muxed_bus_oe, pump_irq_in, standby_flag_n_o, standby_flag_n_oe, half_clock_out;
	logic [15:0] req_addr, pc_out;
	logic [14:0] ext_addr_bus;
	logic [7:0] req_wdata, rsp_rdata, muxed_bus_i, muxed_bus_o;
	int error_cnt, checked;
	localparam logic [7:0] KEY = 8'h3C;
	wire logic [3:0] sel_now = {data_mem_select, prog_mem_select, !secondary_select_n,
		!pump_select_n};

	mcbd_top i_mcbd_top (.*);
	mcbd_pump_model #(.KEY(KEY)) i_mcbd_pump_model (.ref_clk(ref_clk), .addr_latch(addr_latch),
		.any_sel(sel_now != 4'h0), .read_strobe_n(read_strobe_n), .bus_o(muxed_bus_o),
		.bus_i(muxed_bus_i));

	// ----------------------------------------
	// shared checks
	// ----------------------------------------
	task automatic ck(string nm, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	function automatic logic [3:0] exp_sel(logic [15:0] a, logic ft, logic bk);
		if (a[15:8] == 8'h10 || a[15:8] == 8'h12) return 4'h1;
		if (a[15:8] == 8'h11) return 4'h2;
		if (a[15:14] == 2'h1) return 4'h8;
		if (a[15]) return (ft && bk) ? 4'h2 : 4'h4;
		return 4'h0;
	endfunction

	// entered and left 1 ns after an edge; back-to-back calls hit the first ready cycle
	task automatic acc(logic [15:0] a, logic wr, logic ft, logic [7:0] wd, logic [7:0] ed);
		int n;
		req_valid = 1;
		req_addr = a;
		req_write = wr;
		req_fetch = ft;
		req_wdata = wd;
		@(posedge ref_clk);
		#1 req_valid = 0;
		ck("busy", 16'h0, 16'(req_ready));
		ck("select", 16'(exp_sel(a, ft, expand_bank)), 16'(sel_now));
		ck("ext_addr", a & 16'h7FFF, 16'(ext_addr_bus));
		repeat (2) @(posedge ref_clk);
		#1 ck("strobes", wr ? 16'h2 : 16'h1, 16'({read_strobe_n, write_strobe_n}));
		ck("bus_oe", 16'(wr), 16'(muxed_bus_oe));
		if (wr) ck("wdata", 16'(wd), 16'(muxed_bus_o));
		n = 3;
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1 n++;
		end
		ck("latency", 16'h7, 16'(n));
		ck("ready_again", 16'h1, 16'(req_ready));
		if (!wr) ck("rdata", 16'(ed), 16'(rsp_rdata));
	endtask

	task automatic rd(logic [15:0] a, logic ft);
		acc(a, 1'b0, ft, 8'h00, exp_sel(a, ft, expand_bank) != 4'h0 ? a[7:0] ^ KEY : 8'hFF);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		int hc = 0;
		logic hp;
		ck("pc", 16'h2000, pc_out);
		ck("idle_pins", 16'h60, 16'({read_strobe_n, write_strobe_n, addr_latch, sel_now}));
		pc_advance = 1;
		repeat (3) @(posedge ref_clk);
		#1 pc_advance = 0;
		ck("pc_step", 16'h2003, pc_out);
		rst = 1;
		@(posedge ref_clk);
		#1 ck("pc_reset", 16'h2000, pc_out);
		rst = 0;
		for (int k = 0; k < 250; k++) begin
			hp = half_clock_out;
			@(posedge ref_clk);
			#1 hc += int'(half_clock_out && !hp);
		end
		ck("half_clock", 16'h1, 16'(hc >= 49 && hc <= 50));
	endtask

	task automatic t_decode;
		logic [15:0] al[$] = '{16'h0FFF, 16'h1000, 16'h10FF, 16'h1100, 16'h11FF, 16'h1200,
			16'h12FF, 16'h1300, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h2000};
		foreach (al[i]) rd(al[i], 1'b0);
	endtask

	task automatic t_bank;
		rd(16'h8000, 1'b1);
		expand_bank = 1;
		@(posedge ref_clk);
		#1 rd(16'h9001, 1'b1);
		rd(16'h9001, 1'b0);
		expand_bank = 0;
	endtask

	task automatic t_write;
		acc(16'h4123, 1'b1, 1'b0, 8'hA5, 8'h00);
		acc(16'h1234, 1'b1, 1'b0, 8'h5A, 8'h00);
	endtask

	task automatic t_irq;
		int p = 0;
		for (int k = 0; k < 80; k++) begin
			pump_irq_in = (k % 40) < 30;
			@(posedge ref_clk);
			#1 p += int'(pump_irq_pulse);
		end
		ck("irq_pulses", 16'h2, 16'(p));
	endtask

	task automatic t_standby;
		power_down = 1;
		repeat (2) @(posedge ref_clk);
		#1 ck("standby_on", 16'h2, 16'({standby_flag_n_oe, standby_flag_n_o}));
		power_down = 0;
		repeat (2) @(posedge ref_clk);
		#1 ck("standby_off", 16'h0, 16'(standby_flag_n_oe));
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		{rst, req_valid, req_write, req_fetch, pc_advance, expand_bank, power_down} = 7'h40;
		pump_irq_in = 0;
		req_addr = 16'h0000;
		req_wdata = 8'h00;
		repeat (5) @(posedge ref_clk);
		#1 rst = 0;
		t_reset;
		t_decode;
		t_bank;
		t_write;
		t_irq;
		t_standby;
		wrap_up;
	end

	// the whole run needs under 1000 cycles; ten times that means a hang
	initial begin
		#200000;
		error_cnt++;
		wrap_up;
	end
endmodule

bind mcbd_top mcbd_checker i_mcbd_checker (.*);
